// ---- core/pis_cfg.svh ----
// constants for the single-phase bus initiator
`ifndef PIS_CFG_SVH
`define PIS_CFG_SVH
`define PIS_CMD_IO_RD     4'h2
`define PIS_CMD_IO_WR     4'h3
`define PIS_CMD_MEM_RD    4'h6
`define PIS_CMD_MEM_WR    4'h7
`define PIS_BE_ALL        4'h0
`define PIS_BE_NONE       4'hF
`define PIS_ADDR_LINEAR   2'b00
`define PIS_DEVSEL_LIMIT  3
`define PIS_ABORT_CYCLES  3'd5
`endif

// ---- core/pis_initiator.sv ----
// single-data-phase bus initiator: memory write, i/o read, i/o write
`include "pis_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module pis_initiator (
  // clock and synchronous reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // requests from the core, same clock domain
  input  wire logic              req_valid_i,
  input  wire pis_pkg::pis_req_t req_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic                   abort_o,
  output logic [31:0]            rdata_o,
  // internal arbiter handshake
  output logic                   int_req_n_o,
  input  wire logic              int_gnt_n_i,
  // bus link, every pin drive paired with its enable
  input  wire logic              pci_clk_i,
  output logic                   frame_n_o,
  output logic                   frame_n_oe_o,
  output logic                   irdy_n_o,
  output logic                   irdy_n_oe_o,
  output logic [31:0]            ad_o,
  output logic                   ad_oe_o,
  input  wire logic [31:0]       ad_i,
  output logic [3:0]             cbe_n_o,
  output logic                   cbe_n_oe_o,
  // target answer pins
  input  wire logic              trdy_n_i,
  input  wire logic              devsel_n_i
);
  // command code for the address phase
  function automatic logic [3:0] cmd_of(input pis_pkg::pis_op_t op);
    case (op)
      pis_pkg::PIS_OP_MEM_WR: cmd_of = `PIS_CMD_MEM_WR;
      pis_pkg::PIS_OP_IO_RD:  cmd_of = `PIS_CMD_IO_RD;
      pis_pkg::PIS_OP_IO_WR:  cmd_of = `PIS_CMD_IO_WR;
      default:                cmd_of = `PIS_CMD_MEM_RD;
    endcase
  endfunction : cmd_of

  // two-stage synchronisers for pins and the link clock
  // every pin is asynchronous to core_clk_i, so only stage two feeds logic
  // stage one may go metastable; nothing but stage two reads it
  logic [1:0]  clk_s_reg;   // link clock, two stages
  logic [1:0]  trdy_s_reg;  // target ready, two stages
  logic [1:0]  dev_s_reg;   // device select, two stages
  logic [1:0]  gnt_s_reg;   // internal grant, two stages
  logic [31:0] ad_s1_reg;   // shared address/data, first stage
  logic [31:0] ad_s2_reg;   // shared address/data, second stage
  logic        clk_d_reg;   // delayed link clock for edge detect
  // transaction state, latched request and data-phase rise counter
  pis_pkg::pis_state_t state_reg, state_next;
  pis_pkg::pis_req_t   req_reg;
  logic [2:0]          cnt_reg;
  always_ff @(posedge core_clk_i) begin
    clk_s_reg  <= {clk_s_reg[0], pci_clk_i};
    trdy_s_reg <= {trdy_s_reg[0], trdy_n_i};
    dev_s_reg  <= {dev_s_reg[0], devsel_n_i};
    gnt_s_reg  <= {gnt_s_reg[0], int_gnt_n_i};
    ad_s1_reg  <= ad_i;
    ad_s2_reg  <= ad_s1_reg;
    clk_d_reg  <= clk_s_reg[1];
  end

  // named decode of synchronised inputs
  // rise of the link clock as seen after the synchroniser
  wire logic rise_w   = clk_s_reg[1] & ~clk_d_reg;
  // active-low pins turned into active-high conditions
  wire logic trdy_w   = ~trdy_s_reg[1];
  wire logic devsel_w = ~dev_s_reg[1];
  wire logic gnt_w    = ~gnt_s_reg[1];
  // operation class of the latched request
  wire logic is_mem_w = (req_reg.op == pis_pkg::PIS_OP_MEM_WR)
                      | (req_reg.op == pis_pkg::PIS_OP_MEM_RD);
  wire logic is_wr_w  = (req_reg.op == pis_pkg::PIS_OP_MEM_WR)
                      | (req_reg.op == pis_pkg::PIS_OP_IO_WR);
  // memory addresses are forced to linear increment, i/o keep byte offset
  wire logic [31:0] addr_w = is_mem_w ? {req_reg.addr[31:2], `PIS_ADDR_LINEAR}
                                      : req_reg.addr;
  // memory write always full word; i/o uses the caller lane mask
  wire logic [3:0] be_w = (req_reg.op == pis_pkg::PIS_OP_MEM_WR) ? `PIS_BE_ALL
                                                               : req_reg.be_n;
  // devsel is only awaited, never required at a fixed clock
  wire logic xfer_w  = trdy_w & devsel_w;
  // no select after the abort limit ends the phase
  wire logic late_w  = ~devsel_w && (cnt_reg >= `PIS_ABORT_CYCLES);

  // how one transaction walks, one step per detected link clock rise except out of idle:
  //   idle  - request latched from req_i, internal request driven low
  //   req   - wait for the synchronised grant at a rise, then claim the bus
  //   addr  - frame low, address on the shared lines, command on cbe
  //   data  - frame high since this is the last phase, irdy low
  //   data  - byte enables on cbe, write data on the shared lines
  //   data  - stay until select and target ready are both seen low, or the abort limit passes without select
  //   turn  - irdy high, shared lines and cbe released
  //   turn  - frame and irdy still driven high for one link clock
  //   idle  - frame and irdy enables dropped, ready for the next request
  // address phase content:
  //   memory cycles force the two low address bits to linear increment
  //   i/o cycles keep the full byte address, low bits give the lane
  // data phase content:
  //   a memory write always moves the full word, all lanes enabled
  //   i/o cycles use the lane mask handed in with the request
  //   reads leave the shared lines undriven so the target can answer
  // completion:
  //   a transfer needs select and target ready low at the same rise
  //   target ready alone, without select, is never taken as a transfer
  //   a target that never selects ends the phase as a master abort
  //   the abort limit sits above the three-clock select window
  //   done_o or abort_o pulses for one core cycle at the end
  //   read data is taken from stage two of the data synchroniser
  // timing hazards:
  //   every pin is seen two to three core cycles after it moves
  //   the link clock must stay well below half the core clock rate
  //   a rise lost by the edge detector would stretch one phase
  //   outputs change a few core cycles after each link clock rise,
  //   so the target sees them settled at the following rise
  // limits:
  //   one transaction in flight; later requests wait in idle
  //   the memory read command is encoded but carries no extra logic
  //   no bursts: every transaction moves at most one word, none on a master abort
  //   the grant is only looked at in req, so an early grant is harmless
  //   a grant dropped during the transaction is not checked here
  //   reset clears every drive and enable, not the synchronisers
  //   hold reset a few cycles so the synchronisers flush

  // state sequencing on sampled bus clock edges
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pis_pkg::PIS_IDLE: if (req_valid_i) state_next = pis_pkg::PIS_REQ;
      pis_pkg::PIS_REQ:  if (rise_w && gnt_w) state_next = pis_pkg::PIS_ADDR;
      pis_pkg::PIS_ADDR: if (rise_w) state_next = pis_pkg::PIS_DATA;
      pis_pkg::PIS_DATA: if (rise_w && (xfer_w || late_w)) state_next = pis_pkg::PIS_TURN;
      pis_pkg::PIS_TURN: if (rise_w) state_next = pis_pkg::PIS_IDLE;
      default:           state_next = pis_pkg::PIS_IDLE;
    endcase
  end

  // registered state, counters and pin drive
  always_ff @(posedge core_clk_i) begin
    // reset: bus released, request withdrawn
    if (rst_i) begin
      state_reg    <= pis_pkg::PIS_IDLE;
      req_reg      <= '0;
      cnt_reg      <= 3'd0;
      req_ready_o  <= 1'b0;
      done_o       <= 1'b0;
      abort_o      <= 1'b0;
      rdata_o      <= 32'h0000_0000;
      int_req_n_o  <= 1'b1;
      frame_n_o    <= 1'b1;
      frame_n_oe_o <= 1'b0;
      irdy_n_o     <= 1'b1;
      irdy_n_oe_o  <= 1'b0;
      ad_o         <= 32'h0000_0000;
      ad_oe_o      <= 1'b0;
      cbe_n_o      <= `PIS_BE_NONE;
      cbe_n_oe_o   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      // pulses last one cycle unless set below
      done_o      <= 1'b0;
      abort_o     <= 1'b0;
      req_ready_o <= (state_next == pis_pkg::PIS_IDLE) && !req_valid_i;
      // take the request and ask the arbiter
      if (state_reg == pis_pkg::PIS_IDLE && req_valid_i) begin
        req_reg     <= req_i;
        int_req_n_o <= 1'b0;
      end
      // address phase: claim the bus
      if (state_reg == pis_pkg::PIS_REQ && state_next == pis_pkg::PIS_ADDR) begin
        frame_n_o    <= 1'b0;
        frame_n_oe_o <= 1'b1;
        irdy_n_o     <= 1'b1;
        irdy_n_oe_o  <= 1'b1;
        ad_o         <= addr_w;
        ad_oe_o      <= 1'b1;
        cbe_n_o      <= cmd_of(req_reg.op);
        cbe_n_oe_o   <= 1'b1;
        cnt_reg      <= 3'd0;
      end
      // data phase: enables and write data
      if (state_reg == pis_pkg::PIS_ADDR && rise_w) begin
        frame_n_o <= 1'b1;                                // single phase: last data
        irdy_n_o  <= 1'b0;
        cbe_n_o   <= be_w;
        ad_o      <= req_reg.wdata;
        ad_oe_o   <= is_wr_w;
      end
      // count rises spent waiting for the target
      if (state_reg == pis_pkg::PIS_DATA && rise_w && cnt_reg != 3'd7)
        cnt_reg <= cnt_reg + 3'd1;
      // end of data phase: release lines, report the outcome
      if (state_reg == pis_pkg::PIS_DATA && state_next == pis_pkg::PIS_TURN) begin
        irdy_n_o    <= 1'b1;
        ad_oe_o     <= 1'b0;
        cbe_n_oe_o  <= 1'b0;
        int_req_n_o <= 1'b1;
        done_o      <= xfer_w;
        abort_o     <= ~xfer_w;
        if (xfer_w && !is_wr_w) rdata_o <= ad_s2_reg;
      end
      // turnaround done: stop driving frame and irdy
      if (state_reg == pis_pkg::PIS_TURN && rise_w) begin
        frame_n_oe_o <= 1'b0;
        irdy_n_oe_o  <= 1'b0;
      end
    end
  end
endmodule : pis_initiator
`default_nettype wire

// ---- core/pis_pkg.sv ----
// types for the single-phase bus initiator
package pis_pkg;
  typedef enum logic [1:0] {
    PIS_OP_MEM_WR = 2'b00,
    PIS_OP_IO_RD  = 2'b01,
    PIS_OP_IO_WR  = 2'b10,
    PIS_OP_MEM_RD = 2'b11
  } pis_op_t;
  typedef struct packed {
    pis_op_t     op;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be_n;
  } pis_req_t;
  typedef enum logic [4:0] {
    PIS_IDLE = 5'b00001,
    PIS_REQ  = 5'b00010,
    PIS_ADDR = 5'b00100,
    PIS_DATA = 5'b01000,
    PIS_TURN = 5'b10000
  } pis_state_t;
endpackage : pis_pkg

// ---- verification/pis_initiator_checker.sv ----
// port assertions for the bus initiator
`timescale 1ns/10ps
`default_nettype none
module pis_initiator_checker (
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic              req_valid_i,
  input wire pis_pkg::pis_req_t req_i,
  input wire logic              int_gnt_n_i,
  input wire logic              frame_n_o,
  input wire logic              irdy_n_o,
  input wire logic [31:0]       ad_o,
  input wire logic [3:0]        cbe_n_o
);
  pis_pkg::pis_req_t q_reg;
  wire logic         m = q_reg.op[0] == q_reg.op[1];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // request of the transfer under way
  always_ff @(posedge core_clk_i) if (req_valid_i) q_reg <= req_i;
  a_cmd_code: assert property ($fell(frame_n_o) |->
    cbe_n_o == {1'b0, m, 1'b1, !q_reg.op[0]}) else $error("command");
  a_cmd_held: assert property ($fell(frame_n_o) |=> $stable(cbe_n_o) [*4])
    else $error("command moved");
  a_mem_low: assert property ($fell(frame_n_o) && m |-> ad_o[1:0] == 2'h0)
    else $error("low bits");
  a_mem_be: assert property ($rose(frame_n_o) && q_reg.op == 2'h0 |-> cbe_n_o == 4'h0)
    else $error("mem enables");
  a_io_addr: assert property ($fell(frame_n_o) && !m |-> ad_o == q_reg.addr)
    else $error("io address");
  a_io_be: assert property ($rose(frame_n_o) && q_reg.op == 2'h2 |->
    cbe_n_o == q_reg.be_n) else $error("io enables");
  a_gnt_first: assert property ($fell(frame_n_o) |-> !int_gnt_n_i)
    else $error("no grant");
  a_one_phase: assert property ($fell(irdy_n_o) |-> $rose(frame_n_o))
    else $error("frame held");
  a_wr_data: assert property ($rose(frame_n_o) && !q_reg.op[0] |-> ad_o == q_reg.wdata)
    else $error("write data");
endmodule : pis_initiator_checker
bind pis_initiator pis_initiator_checker chk (.*);
`default_nettype wire

// ---- verification/pis_initiator_tb.sv ----
// bench for the bus initiator
`timescale 1ns/10ps
`default_nettype none
module pis_initiator_tb;
  logic core_clk_i = 1'b0, rst_i = 1'b1, pci_clk_i = 1'b0;
  logic req_valid_i = 1'b0, int_gnt_n_i = 1'b1;
  logic req_ready_o, done_o, abort_o, int_req_n_o, frame_n_o, frame_n_oe_o, irdy_n_o;
  logic irdy_n_oe_o, ad_oe_o, cbe_n_oe_o, trdy_n_i, devsel_n_i;
  logic [31:0] rdata_o, ad_o, tad;
  logic [3:0]  cbe_n_o;
  logic [2:0]  dly = 3'h0;
  pis_pkg::pis_req_t req_i = '0;
  int bad_count = 0, checked = 0;
  // shared lines; control lines pulled up when released
  wire logic [31:0] ad_i = ad_oe_o ? ad_o : tad;
  wire logic fr_w = frame_n_oe_o ? frame_n_o : 1'b1;
  wire logic ir_w = irdy_n_oe_o ? irdy_n_o : 1'b1;
  always #20 core_clk_i = ~core_clk_i;
  initial #7 forever #160 pci_clk_i = ~pci_clk_i;
  always @(posedge core_clk_i) int_gnt_n_i <= int_req_n_o; // arbiter grants every request
  pis_initiator uut (.*);
  pis_target tgt (.pci_clk_i, .frame_n_i(fr_w), .irdy_n_i(ir_w), .dly_i(dly),
    .devsel_n_o(devsel_n_i), .trdy_n_o(trdy_n_i), .ad_o(tad));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // one transfer, target decoding after d clocks; ab expects a master abort
  task automatic xfer(input logic [1:0] op, input logic [31:0] a, input logic [3:0] be,
      input logic [2:0] d, input logic ab);
    int n;
    @(posedge core_clk_i);
    for (n = 0; n < 50 && req_ready_o !== 1'b1; n++) @(posedge core_clk_i);
    chk({31'h0, req_ready_o}, 32'h1);
    dly <= d;
    req_i <= '{pis_pkg::pis_op_t'(op), a, ~a, be};
    req_valid_i <= 1'b1;
    for (n = 0; n < 50 && int_req_n_o !== 1'b0; n++) @(posedge core_clk_i);
    chk({31'h0, int_req_n_o}, 32'h0);
    req_valid_i <= 1'b0;
    for (n = 0; n < 600 && done_o !== 1'b1 && abort_o !== 1'b1; n++) @(posedge core_clk_i);
    chk({31'h0, abort_o}, {31'h0, ab});
    chk({29'h0, ~irdy_n_o, ad_oe_o, cbe_n_oe_o}, 32'h0);
    if (op == 2'h1) chk(rdata_o, 32'h5A5A_A5A5 ^ {29'h0, d});
    if (n == 600) begin
      chk(32'(n), 32'h0);
      final_report();
    end
  endtask : xfer
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    xfer(2'h0, 32'h0000_0017, 4'h0, 3'h0, 1'b0);
    xfer(2'h1, 32'h0000_0010, 4'h0, 3'h1, 1'b0);
    xfer(2'h2, 32'h0000_0015, 4'hD, 3'h2, 1'b0);
    xfer(2'h2, 32'h0000_0014, 4'h0, 3'h7, 1'b1);
    xfer(2'h1, 32'h0000_0013, 4'h0, 3'h2, 1'b0);
    final_report();
  end
endmodule : pis_initiator_tb
`default_nettype wire

// ---- verification/pis_target.sv ----
// bus target model answering the initiator
`timescale 1ns/10ps
`default_nettype none
module pis_target (
  input  wire logic        pci_clk_i,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic [2:0]  dly_i,
  output logic             devsel_n_o,
  output logic             trdy_n_o,
  output logic [31:0]      ad_o
);
  logic       busy_reg = 1'b0;
  logic [2:0] cnt_reg  = 3'h0;
  logic [1:0] sel_reg  = 2'h3;
  // read word when selected, its inverse otherwise; low bits carry dly_i
  assign ad_o = {32{devsel_n_o}} ^ (32'h5A5A_A5A5 ^ {29'h0, dly_i});
  // decode after dly_i clocks; 7 never answers
  always @(posedge pci_clk_i) begin
    if (!frame_n_i && !busy_reg) {busy_reg, cnt_reg} <= {1'b1, 3'h0};
    else if (busy_reg) begin
      cnt_reg  <= cnt_reg + 3'h1;
      busy_reg <= !(frame_n_i && irdy_n_i) && (irdy_n_i || sel_reg[0]);
      if (!irdy_n_i && !sel_reg[0]) sel_reg <= 2'h3;
      else if (cnt_reg == dly_i) sel_reg <= 2'h0;
    end
  end
  // outputs move half a clock after each decision
  always @(negedge pci_clk_i) {devsel_n_o, trdy_n_o} <= sel_reg;
endmodule : pis_target
`default_nettype wire
